// ===== scg_clk_cell.sv
`timescale 1ns/100ps
// latch-based clock enable cell: enable captured while clock is low,
// so the gated clock never shows a runt pulse
module scg_clk_cell (
    input  wire logic mclk,
    input  wire logic en,
    output logic      gclk
);
    logic en_lat;

    // transparent low latch
    always_latch begin
        if (!mclk) begin
            en_lat <= en;
        end
    end

    assign gclk = mclk & en_lat;
endmodule : scg_clk_cell

// ===== scg_defines.svh
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
// register byte offsets
`define SCG_RUN_OFS      12'h104
`define SCG_SLEEP_OFS    12'h114
`define SCG_DEEP_OFS     12'h124
`define SCG_MODE_OFS     12'h130
`define SCG_FAULT_OFS    12'h134
// gating register reset value and writable bits
`define SCG_GATE_RST     32'h00000000
`define SCG_GATE_MASK    32'h03030011
// field positions in the gating registers
`define SCG_BIT_CMP1     25
`define SCG_BIT_CMP0     24
`define SCG_BIT_GPA      17
`define SCG_BIT_GPB      16
`define SCG_BIT_SYNC_SERIAL0_CLOCK_ENABLE     4
`define SCG_BIT_ASI0     0
// field positions in the mode register, and the number of units
`define SCG_BIT_ACG      0
`define SCG_MODE_LSB     1
`define SCG_NUM_UNITS    6
`endif

// ===== scg_gate_ctrl.sv
`timescale 1ns/100ps
`include "scg_defines.svh"
// Notes on behaviour
// - set bit clocks unit, clear bit stops it
// - access to gated unit gets bus fault
// - gating registers reset to all zeros
// - active register follows the power mode
// - low-power registers need auto gating select
// - bit 4 sync serial, bit 0 async serial
// - reserved bits read zero, control nothing
module scg_gate_ctrl
    import scg_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      hsel,
    input  wire logic [11:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      periph_access,
    input  wire logic [`SCG_NUM_UNITS-1:0] periph_target,
    output logic                           periph_fault,
    output logic      [`SCG_NUM_UNITS-1:0] unit_clk_en,
    output logic      [`SCG_NUM_UNITS-1:0] unit_clk
);
    localparam int NU = `SCG_NUM_UNITS;

    // bit position of each unit in the gating word
    localparam int UNIT_POS [NU] = '{`SCG_BIT_ASI0, `SCG_BIT_SYNC_SERIAL0_CLOCK_ENABLE,
        `SCG_BIT_GPB, `SCG_BIT_GPA, `SCG_BIT_CMP0, `SCG_BIT_CMP1};

    //--------------------------------------------------------------
    // bus address phase capture
    //--------------------------------------------------------------
    logic        wr_pend_reg, wr_pend_next;
    logic [11:0] addr_reg, addr_next;
    logic        take;

    assign take = hsel & hready & htrans[1];

    // only NONSEQ/SEQ start a transfer; IDLE and BUSY are ignored
    always_comb begin
        wr_pend_next = take & hwrite;
        addr_next    = take ? haddr : addr_reg;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            addr_reg    <= addr_next;
        end
    end

    //--------------------------------------------------------------
    // gating and mode registers
    //--------------------------------------------------------------
    logic [31:0] run_reg, run_next;
    logic [31:0] sleep_reg, sleep_next;
    logic [31:0] deep_reg, deep_next;
    logic        acg_reg, acg_next;
    scg_mode_t   mode_reg, mode_next;
    logic [1:0]  wmode;

    assign wmode = hwdata[`SCG_MODE_LSB+1:`SCG_MODE_LSB];

    // reserved bits masked on write so they stay zero
    always_comb begin
        run_next   = run_reg;
        sleep_next = sleep_reg;
        deep_next  = deep_reg;
        acg_next   = acg_reg;
        mode_next  = mode_reg;
        if (wr_pend_reg) begin
            if (addr_reg == `SCG_RUN_OFS) begin
                run_next = hwdata & `SCG_GATE_MASK;
            end else if (addr_reg == `SCG_SLEEP_OFS) begin
                sleep_next = hwdata & `SCG_GATE_MASK;
            end else if (addr_reg == `SCG_DEEP_OFS) begin
                deep_next = hwdata & `SCG_GATE_MASK;
            end else if (addr_reg == `SCG_MODE_OFS) begin
                acg_next = hwdata[`SCG_BIT_ACG];
                // unknown code keeps the current mode
                if (wmode == 2'h0) begin
                    mode_next = SCG_RUN;
                end else if (wmode == 2'h1) begin
                    mode_next = SCG_SLEEP;
                end else if (wmode == 2'h2) begin
                    mode_next = SCG_DEEP;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_reg   <= `SCG_GATE_RST;
            sleep_reg <= `SCG_GATE_RST;
            deep_reg  <= `SCG_GATE_RST;
            acg_reg   <= 1'b0;
            mode_reg  <= SCG_RUN;
        end else begin
            run_reg   <= run_next;
            sleep_reg <= sleep_next;
            deep_reg  <= deep_next;
            acg_reg   <= acg_next;
            mode_reg  <= mode_next;
        end
    end

    //--------------------------------------------------------------
    // active gating word and unit enables
    //--------------------------------------------------------------
    logic [31:0]   active;
    logic [NU-1:0] en_next, fault_next;

    // without auto gating the run register holds in every mode
    always_comb begin
        active = run_reg;
        case (mode_reg)
            SCG_SLEEP: active = acg_reg ? sleep_reg : run_reg;
            SCG_DEEP:  active = acg_reg ? deep_reg : run_reg;
            default:   active = run_reg;
        endcase
    end

    logic unit_fault_next;

    // per unit: enable, glitch-free clock, fault decode
    for (genvar i = 0; i < NU; i++) begin : g_unit
        assign en_next[i] = active[UNIT_POS[i]];
        assign fault_next[i] = periph_target[i] & ~active[UNIT_POS[i]];
        scg_clk_cell u_cell (
            .mclk (mclk),
            .en   (unit_clk_en[i]),
            .gclk (unit_clk[i])
        );
    end

    assign unit_fault_next = periph_access & (|fault_next);

    always_ff @(posedge mclk) begin
        if (rst) begin
            unit_clk_en  <= '0;
            periph_fault <= 1'b0;
        end else begin
            unit_clk_en  <= en_next;
            periph_fault <= unit_fault_next;
        end
    end

    //--------------------------------------------------------------
    // read data; answers in the first data-phase cycle, always OKAY
    //--------------------------------------------------------------
    logic [31:0] rd_next;

    // next values, so a read right behind a write sees the new word
    always_comb begin
        rd_next = 32'h00000000;
        if (take && !hwrite) begin
            if (haddr == `SCG_RUN_OFS) begin
                rd_next = run_next;
            end else if (haddr == `SCG_SLEEP_OFS) begin
                rd_next = sleep_next;
            end else if (haddr == `SCG_DEEP_OFS) begin
                rd_next = deep_next;
            end else if (haddr == `SCG_MODE_OFS) begin
                rd_next[`SCG_BIT_ACG] = acg_next;
                rd_next[`SCG_MODE_LSB+1:`SCG_MODE_LSB] = mode_next;
            end else if (haddr == `SCG_FAULT_OFS) begin
                rd_next[NU-1:0] = en_next;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rd_next;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    property p_reset_zero;
        @(posedge mclk) $fell(rst) |-> (sleep_reg == 32'h0)
            && (deep_reg == 32'h0) && (unit_clk_en == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("gating state not zero after reset");

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        ((sleep_reg | deep_reg) & ~32'h03030011) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved gating bit set");

    property p_run_apply;
        @(posedge mclk) disable iff (rst)
        (mode_reg == SCG_RUN) ##1 (mode_reg == SCG_RUN)
            |-> unit_clk_en[0] == $past(run_reg[0]);
    endproperty
    a_run_apply: assert property (p_run_apply)
        else $error("run register not applied");

    property p_sleep_apply;
        @(posedge mclk) disable iff (rst)
        (mode_reg == SCG_SLEEP && acg_reg)
            |=> unit_clk_en[5] == $past(sleep_reg[25]);
    endproperty
    a_sleep_apply: assert property (p_sleep_apply)
        else $error("sleep register not applied");

    property p_deep_apply;
        @(posedge mclk) disable iff (rst)
        (mode_reg == SCG_DEEP && acg_reg)
            |=> unit_clk_en[3] == $past(deep_reg[17]);
    endproperty
    a_deep_apply: assert property (p_deep_apply)
        else $error("deep sleep register not applied");

    property p_no_acg;
        @(posedge mclk) disable iff (rst)
        (!acg_reg) |=> unit_clk_en[1] == $past(run_reg[4]);
    endproperty
    a_no_acg: assert property (p_no_acg)
        else $error("low power register used without auto gating");

    property p_fault;
        @(posedge mclk) disable iff (rst)
        (periph_access && periph_target[0] && !active[0]) |=> periph_fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("access to gated unit not faulted");

    property p_no_fault;
        @(posedge mclk) disable iff (rst)
        !periph_access |=> !periph_fault;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault without access");

    // high phase of the gated clock carries the enable latched before it
    property p_clk_off;
        @(negedge mclk) disable iff (rst)
        unit_clk[2] == $past(unit_clk_en[2]);
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("gated unit still clocked");
endmodule : scg_gate_ctrl

// ===== scg_pkg.sv
package scg_pkg;
    // power mode of the system
    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP
    } scg_mode_t;
endpackage : scg_pkg

// ===== tb_top.sv
`timescale 1ns/100ps
`include "scg_defines.svh"
module tb_top;
    logic        mclk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic        periph_access;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        periph_fault;
    logic [5:0]  periph_target;
    logic [5:0]  unit_clk_en;
    logic [5:0]  unit_clk;
    int          err_total;
    int          check_count;
    // ----------------------------------------
    // clock, bus loop-back and device
    // ----------------------------------------
    always #10 mclk = ~mclk;
    scg_gate_ctrl dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .periph_access(periph_access),
        .periph_target(periph_target), .periph_fault(periph_fault),
        .unit_clk_en(unit_clk_en), .unit_clk(unit_clk));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // bounded wait for hready, sampled at the rising edge like the slave
    task wait_rdy(output logic [31:0] rd);
        logic ok;
        ok = 1'b0;
        rd = 32'h00000000;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) begin
                ok = 1'b1;
                rd = hrdata;
                check("hresp", {31'h0, hresp}, 32'h00000000);
            end
        end
        if (!ok) begin
            err_total++;
            complete_run();
        end
    endtask : wait_rdy
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        logic [31:0] x;
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(x);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : bus
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h00000000, x);
        check(nm, x, e);
    endtask : rdchk
    task do_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rdchk("run", `SCG_RUN_OFS, 32'h00000000);
        rdchk("sleep", `SCG_SLEEP_OFS, 32'h00000000);
        rdchk("deep", `SCG_DEEP_OFS, 32'h00000000);
        rdchk("active", `SCG_FAULT_OFS, 32'h00000000);
        check("en", {26'h0, unit_clk_en}, 32'h00000000);
        $display("test reset done");
    endtask : t_reset
    // reserved bits must drop out, unmapped space reads zero
    task t_fields;
        logic [11:0] a [4] = '{`SCG_RUN_OFS, `SCG_SLEEP_OFS, `SCG_DEEP_OFS,
                               12'h200};
        logic [31:0] e [4] = '{32'h03030011, 32'h03030011, 32'h03030011,
                               32'h00000000};
        logic [31:0] x;
        for (int i = 0; i < 4; i++) begin
            wr(a[i], 32'hFFFFFFFF);
            rdchk("ones", a[i], e[i]);
            wr(a[i], 32'h00000000);
            rdchk("zero", a[i], 32'h00000000);
        end
        // software read-modify-write hands back the bits it read
        wr(`SCG_SLEEP_OFS, 32'h00000010);
        bus(1'b0, `SCG_SLEEP_OFS, 32'h00000000, x);
        wr(`SCG_SLEEP_OFS, x | 32'h01000000);
        rdchk("rmw", `SCG_SLEEP_OFS, 32'h01000010);
        wr(`SCG_SLEEP_OFS, 32'h00000000);
        $display("test fields done");
    endtask : t_fields
    // mode word: bits 2:1 power mode, bit 0 auto gating select;
    // mode code 3 must leave the current mode in place
    task t_modes;
        logic [2:0] cfg [7] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h5, 3'h4, 3'h1};
        logic [5:0] exp [7] = '{6'h03, 6'h03, 6'h30, 6'h30, 6'h0C, 6'h03,
                                6'h03};
        wr(`SCG_RUN_OFS, 32'h00000011);
        wr(`SCG_SLEEP_OFS, 32'h03000000);
        wr(`SCG_DEEP_OFS, 32'h00030000);
        for (int i = 0; i < 7; i++) begin
            wr(`SCG_MODE_OFS, {29'h0, cfg[i]});
            @(negedge mclk);
            @(negedge mclk);
            check("en", {26'h0, unit_clk_en}, {26'h0, exp[i]});
            rdchk("active", `SCG_FAULT_OFS, {26'h0, exp[i]});
            @(posedge mclk);
            #5;
            check("clk hi", {26'h0, unit_clk}, {26'h0, exp[i]});
            @(negedge mclk);
            #1;
            check("clk lo", {26'h0, unit_clk}, 32'h00000000);
        end
        $display("test modes done");
    endtask : t_modes
    // gated units fault, enabled ones answer quietly
    task t_fault;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 6; i++) begin
                @(posedge mclk);
                periph_access <= 1'b1;
                periph_target <= 6'h01 << i;
                @(posedge mclk);
                periph_access <= 1'b0;
                @(negedge mclk);
                check("fault", {31'h0, periph_fault},
                      {31'h0, (k == 0 && i > 1)});
            end
            wr(`SCG_RUN_OFS, 32'h03030011);
            @(negedge mclk);
            @(negedge mclk);
        end
        $display("test fault done");
    endtask : t_fault
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mclk          = 1'b0;
        rst           = 1'b1;
        hsel          = 1'b0;
        hwrite        = 1'b0;
        haddr         = 12'h000;
        htrans        = 2'h0;
        hsize         = 3'h2;
        hwdata        = 32'h00000000;
        periph_access = 1'b0;
        periph_target = 6'h00;
        err_total     = 0;
        check_count   = 0;
        do_reset();
        t_reset();
        t_fields();
        t_modes();
        t_fault();
        // second reset in mid-run must clear everything again
        do_reset();
        t_reset();
        complete_run();
    end
endmodule : tb_top
